//--- hdl/mps_pkg.sv
// Constants shared by the multiplexed pin select block and its timer.
package mps_pkg;
    // Register byte offsets on the APB slave.
    localparam logic [11:0] PIN_CTRL_OFS    = 12'h000;
    localparam logic [11:0] TIMER_RELOAD_OFS = 12'h004;
    localparam logic [11:0] TIMER_COUNT_OFS = 12'h008;
    localparam logic [11:0] PIN_STATUS_OFS  = 12'h00c;

    // Field positions in the pin control register.
    localparam int TIMER_OUTPUT_CTRL_LO     = 0;
    localparam int TIMER_OUTPUT_CTRL_HI     = 1;
    localparam int DMA_DEST_MODE_HI         = 2;
    localparam int DMA_SRC_MODE_HI          = 3;
    localparam int SERIAL_CLOCK_CH1_DISABLE = 4;
    localparam int CLEAR_TO_SEND_CH1_ENABLE = 5;
    localparam int TIMER_RUN                = 6;
    localparam int PIN_CTRL_BITS            = 7;

    // Field positions in the pin status register.
    localparam int STAT_SEL_TIMER = 0;
    localparam int STAT_SEL_DMA   = 1;
    localparam int STAT_SEL_TEND  = 2;
    localparam int STAT_SEL_CTS   = 3;
    localparam int STAT_PULSE     = 4;

    // Values after reset.
    localparam logic [6:0]  PIN_CTRL_RESET     = 7'h00;
    localparam logic [15:0] TIMER_RELOAD_RESET = 16'hffff;

    // The reload timer counts once every this many system clocks.
    localparam int TIMER_PRESCALE_DIV = 20;
    localparam int TIMER_RELOAD_WIDTH = 16;
endpackage

//--- hdl/mps_timer_if.sv
// Carrier between the pin select top and its reload timer.
`timescale 1ns/10ps
`default_nettype none
interface mps_timer_if #(parameter int WIDTH = 16);
    logic [WIDTH-1:0] reloadValue;
    logic             reloadLoad;
    logic             run;
    logic [WIDTH-1:0] count;
    logic             timerPulseOut;

    modport ctrl  (output reloadValue, output reloadLoad, output run,
                   input count, input timerPulseOut);
    modport timer (input reloadValue, input reloadLoad, input run,
                   output count, output timerPulseOut);
endinterface
`default_nettype wire

//--- hdl/mps_reload_timer.sv
// Reload timer: prescaled down counter with a toggling pulse output.
`timescale 1ns/10ps
`default_nettype none
module mps_reload_timer #(
    parameter int WIDTH = mps_pkg::TIMER_RELOAD_WIDTH
) (
    input  wire logic  clk_sys,
    input  wire logic  rst,
    mps_timer_if.timer tmr
);
    localparam int DIV = mps_pkg::TIMER_PRESCALE_DIV;
    localparam int PW  = $clog2(DIV);
    localparam logic [PW-1:0] PRE_LAST = PW'(DIV - 1);

    if (WIDTH < 2)
        $error("mps_reload_timer: WIDTH must be at least 2");

    logic [PW-1:0]    prescale;
    logic [WIDTH-1:0] count;
    logic             pulse;
    wire              tick      = tmr.run && (prescale == PRE_LAST);
    wire              countZero = (count == '0);

    assign tmr.count         = count;
    assign tmr.timerPulseOut = pulse;

    always_ff @(posedge clk_sys)
    begin
        if (rst || !tmr.run || tick)
            prescale <= '0;
        else
            prescale <= prescale + PW'(1);
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            count <= WIDTH'(mps_pkg::TIMER_RELOAD_RESET);
            pulse <= 1'b0;
        end
        else if (tmr.reloadLoad)
            count <= tmr.reloadValue;
        else if (tick)
        begin
            count <= countZero ? tmr.reloadValue : count - WIDTH'(1);
            pulse <= countZero ? ~pulse : pulse;
        end
    end

    a_prescale_bound: assert property (
        @(posedge clk_sys) disable iff (rst)
        tick |-> $past(tmr.run) && !$past(tick))
        else $error("timer ticked faster than the prescale rate");
endmodule // mps_reload_timer
`default_nettype wire

//--- hdl/mps_pin_select.sv
// Pin function multiplexer for four shared pins, with APB control.
//
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module mps_pin_select #(
    parameter int RELOAD_WIDTH = mps_pkg::TIMER_RELOAD_WIDTH
) (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        addressLine18,
    input  wire logic        asyncSerialClockCh0Out,
    input  wire logic        asyncSerialClockCh0OutEn,
    input  wire logic        asyncSerialClockCh1Out,
    input  wire logic        asyncSerialClockCh1OutEn,
    input  wire logic        dmaLastWrite,
    output logic             pinAddrTimer,
    input  wire logic        pinClk0ReqIn,
    output logic             pinClk0ReqOut,
    output logic             pinClk0ReqOe,
    input  wire logic        pinClk1EndIn,
    output logic             pinClk1EndOut,
    output logic             pinClk1EndOe,
    input  wire logic        pinRxCtsIn,
    output logic             asyncSerialClockCh0In,
    output logic             dmaRequestCh0N,
    output logic             asyncSerialClockCh1In,
    output logic             clockedSerialRx,
    output logic             clearToSendCh1N
);
    if (RELOAD_WIDTH < 2 || RELOAD_WIDTH > 32)
        $error("mps_pin_select: RELOAD_WIDTH must be 2 to 32");

    localparam int NSYNC = 3;
    localparam int CW    = mps_pkg::PIN_CTRL_BITS;

    mps_timer_if #(.WIDTH(RELOAD_WIDTH)) tmrBus ();

    mps_reload_timer #(.WIDTH(RELOAD_WIDTH)) u_timer (
        .clk_sys (clk_sys),
        .rst     (rst),
        .tmr     (tmrBus.timer)
    );

    logic [CW-1:0]           pinCtrl;
    logic [RELOAD_WIDTH-1:0] reloadReg;
    logic                    reloadLoad;
    logic [NSYNC-1:0]        syncFirst;
    logic [NSYNC-1:0]        syncSecond;
    logic [31:0]             next_prdata;
    logic                    next_pslverr;

    // Pins come from outside the clock domain, so each gets two flops.
    // They reset to the idle high level so no false request follows reset.
    wire [NSYNC-1:0] pinRaw = {pinRxCtsIn, pinClk1EndIn, pinClk0ReqIn};
    for (genvar i = 0; i < NSYNC; i++)
    begin : g_sync
        always_ff @(posedge clk_sys)
        begin
            if (rst)
            begin
                syncFirst[i]  <= 1'b1;
                syncSecond[i] <= 1'b1;
            end
            else
            begin
                syncFirst[i]  <= pinRaw[i];
                syncSecond[i] <= syncFirst[i];
            end
        end
    end
    wire clk0Pin = syncSecond[0];
    wire clk1Pin = syncSecond[1];
    wire rxPin   = syncSecond[2];

    // APB decoding.
    wire accessDone = psel && penable && pready;
    wire isCtrl     = (paddr == mps_pkg::PIN_CTRL_OFS);
    wire isReload   = (paddr == mps_pkg::TIMER_RELOAD_OFS);
    wire isCount    = (paddr == mps_pkg::TIMER_COUNT_OFS);
    wire isStatus   = (paddr == mps_pkg::PIN_STATUS_OFS);
    wire isMapped   = isCtrl || isReload || isCount || isStatus;
    wire writeCtrl  = accessDone && pwrite && isCtrl;
    wire writeRel   = accessDone && pwrite && isReload;
    wire setupPhase = psel && !penable;

    // Function selection from the control bits.
    // timer output select
    wire selTimer = pinCtrl[mps_pkg::TIMER_OUTPUT_CTRL_LO]
                 || pinCtrl[mps_pkg::TIMER_OUTPUT_CTRL_HI];
    wire selDma   = pinCtrl[mps_pkg::DMA_DEST_MODE_HI]
                 || pinCtrl[mps_pkg::DMA_SRC_MODE_HI];
    wire selTend  = pinCtrl[mps_pkg::SERIAL_CLOCK_CH1_DISABLE];
    wire selCts   = pinCtrl[mps_pkg::CLEAR_TO_SEND_CH1_ENABLE];

    wire [4:0] statusBits = {tmrBus.timerPulseOut, selCts, selTend,
                             selDma, selTimer};

    assign tmrBus.reloadValue = reloadReg;
    assign tmrBus.reloadLoad  = reloadLoad;
    assign tmrBus.run         = pinCtrl[mps_pkg::TIMER_RUN];

    // Read data and the error flag decode from the address alone; the
    // flop stage below captures them in the setup cycle.
    always_comb
    begin
        next_prdata  = 32'h0000_0000;
        next_pslverr = 1'b0;
        if (isCtrl)
            next_prdata[CW-1:0] = pinCtrl;
        else if (isReload)
            next_prdata[RELOAD_WIDTH-1:0] = reloadReg;
        else if (isCount)
            next_prdata[RELOAD_WIDTH-1:0] = tmrBus.count;
        else if (isStatus)
            next_prdata[4:0] = statusBits;
        else
            next_pslverr = 1'b1;
    end

    // The slave answers in the first access cycle; pready is a flop.
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= setupPhase;
            prdata  <= (setupPhase && !pwrite) ? next_prdata : prdata;
            pslverr <= setupPhase && next_pslverr;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            pinCtrl    <= mps_pkg::PIN_CTRL_RESET;
            reloadReg  <= RELOAD_WIDTH'(mps_pkg::TIMER_RELOAD_RESET);
            reloadLoad <= 1'b0;
        end
        else
        begin
            pinCtrl    <= writeCtrl ? pwdata[CW-1:0] : pinCtrl;
            reloadReg  <= writeRel ? pwdata[RELOAD_WIDTH-1:0] : reloadReg;
            reloadLoad <= writeRel;
        end
    end

    // Next pin and internal values.
    // address or timer pulse
    wire next_addrTimer = selTimer ? tmrBus.timerPulseOut : addressLine18;
    // pin driven only as a serial clock
    wire next_clk0Oe    = !selDma && asyncSerialClockCh0OutEn;
    // active-low transfer end during last write
    wire next_clk1Out   = selTend ? !dmaLastWrite : asyncSerialClockCh1Out;
    // transfer end always drives the pin
    wire next_clk1Oe    = selTend || asyncSerialClockCh1OutEn;
    wire next_dmaReqN   = selDma ? clk0Pin : 1'b1;
    wire next_clk0In    = selDma ? 1'b0 : clk0Pin;
    wire next_clk1In    = selTend ? 1'b0 : clk1Pin;
    wire next_ctsN      = selCts ? rxPin : 1'b1;
    wire next_rx        = selCts ? 1'b1 : rxPin;

    // Registering the pins costs one cycle but keeps every output glitch
    // free while control bits change.
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            // The pins carry their default functions while reset is held,
            // so the address line and serial clocks pass straight on.
            pinAddrTimer          <= addressLine18;
            pinClk0ReqOut         <= asyncSerialClockCh0Out;
            pinClk0ReqOe          <= asyncSerialClockCh0OutEn;
            pinClk1EndOut         <= asyncSerialClockCh1Out;
            pinClk1EndOe          <= asyncSerialClockCh1OutEn;
            asyncSerialClockCh0In <= 1'b0;
            dmaRequestCh0N        <= 1'b1;
            asyncSerialClockCh1In <= 1'b0;
            clockedSerialRx       <= 1'b1;
            clearToSendCh1N       <= 1'b1;
        end
        else
        begin
            pinAddrTimer          <= next_addrTimer;
            pinClk0ReqOut         <= asyncSerialClockCh0Out;
            pinClk0ReqOe          <= next_clk0Oe;
            pinClk1EndOut         <= next_clk1Out;
            pinClk1EndOe          <= next_clk1Oe;
            asyncSerialClockCh0In <= next_clk0In;
            dmaRequestCh0N        <= next_dmaReqN;
            asyncSerialClockCh1In <= next_clk1In;
            clockedSerialRx       <= next_rx;
            clearToSendCh1N       <= next_ctsN;
        end
    end

    // Every output passes one flop, so each check compares it with the
    // mux inputs one clock earlier. The checks are split per function
    // so that a failure names the pin that went wrong.
    a_addr_line_pass: assert property (
        @(posedge clk_sys) disable iff (rst)
        !selTimer |=> pinAddrTimer == $past(addressLine18))
        else $error("address line not passed while timer deselected");

    a_timer_pulse_pin: assert property (
        @(posedge clk_sys) disable iff (rst)
        selTimer |=> pinAddrTimer == $past(tmrBus.timerPulseOut))
        else $error("timer pulse not on shared address pin");

    a_clk0_serial: assert property (
        @(posedge clk_sys) disable iff (rst)
        !selDma |=> pinClk0ReqOe == $past(asyncSerialClockCh0OutEn)
                    && asyncSerialClockCh0In == $past(clk0Pin))
        else $error("serial clock zero not on shared pin");

    a_dma_req_path: assert property (
        @(posedge clk_sys) disable iff (rst)
        selDma |=> !pinClk0ReqOe && dmaRequestCh0N == $past(clk0Pin)
                   && !asyncSerialClockCh0In)
        else $error("DMA request path wrong while selected");

    a_tend_drive: assert property (
        @(posedge clk_sys) disable iff (rst)
        selTend && dmaLastWrite |=> pinClk1EndOe && !pinClk1EndOut)
        else $error("transfer end not driven low on last write");

    a_tend_idle: assert property (
        @(posedge clk_sys) disable iff (rst)
        selTend && !dmaLastWrite |=> pinClk1EndOe && pinClk1EndOut)
        else $error("transfer end active outside the last write");

    a_clk1_revert: assert property (
        @(posedge clk_sys) disable iff (rst)
        !selTend |=> pinClk1EndOe == $past(asyncSerialClockCh1OutEn)
                     && pinClk1EndOut == $past(asyncSerialClockCh1Out)
                     && asyncSerialClockCh1In == $past(clk1Pin))
        else $error("serial clock one not restored");

    a_clk1_in_gate: assert property (
        @(posedge clk_sys) disable iff (rst)
        selTend |=> !asyncSerialClockCh1In)
        else $error("serial clock one input not gated");

    a_cts_select: assert property (
        @(posedge clk_sys) disable iff (rst)
        selCts |=> clearToSendCh1N == $past(rxPin) && clockedSerialRx)
        else $error("clear to send path wrong");

    a_rx_select: assert property (
        @(posedge clk_sys) disable iff (rst)
        !selCts |=> clockedSerialRx == $past(rxPin) && clearToSendCh1N)
        else $error("receive data not passed while selected");

    a_idle_inputs: assert property (
        @(posedge clk_sys) disable iff (rst)
        !selDma && !selCts ##1 !selDma
        |-> dmaRequestCh0N && clearToSendCh1N)
        else $error("unselected input not at inactive level");

    // Bus checks.
    a_apb_answer: assert property (
        @(posedge clk_sys) disable iff (rst)
        setupPhase |=> pready && (pslverr == !$past(isMapped)))
        else $error("APB answer missing or wrong error flag");

    a_pready_pulse: assert property (
        @(posedge clk_sys) disable iff (rst)
        pready |=> !pready)
        else $error("pready held for more than one cycle");

    a_ctrl_write: assert property (
        @(posedge clk_sys) disable iff (rst)
        writeCtrl |=> pinCtrl == $past(pwdata[CW-1:0]))
        else $error("control write did not land");

    a_prdata_hold: assert property (
        @(posedge clk_sys) disable iff (rst)
        !(setupPhase && !pwrite) |=> $stable(prdata))
        else $error("read data changed outside a read setup");
endmodule // mps_pin_select
`default_nettype wire

//--- testbench/mps_pin_partner.sv
// External devices that share three of the four multiplexed pins.
`timescale 1ns/10ps
`default_nettype none
module mps_pin_partner (
    input  wire logic extReq,
    input  wire logic extClk1,
    input  wire logic extRx,
    input  wire logic clk0Out,
    input  wire logic clk0Oe,
    input  wire logic clk1Out,
    input  wire logic clk1Oe,
    output logic      clk0Pin,
    output logic      clk1Pin,
    output logic      rxPin
);
    // The far device yields while the block drives the pin.
    assign clk0Pin = clk0Oe ? clk0Out : extReq;
    assign clk1Pin = clk1Oe ? clk1Out : extClk1;
    assign rxPin = extRx;
endmodule // mps_pin_partner
`default_nettype wire

//--- testbench/multiplexed_pin_select_tb.sv
// Self-checking bench for the multiplexed pin select block.
`timescale 1ns/10ps
`default_nettype none
module multiplexed_pin_select_tb;
    logic        clk_sys, rst, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, ctl;
    logic        err, addressLine18, dmaLastWrite, extReq, extClk1, extRx;
    logic        asyncSerialClockCh0Out, asyncSerialClockCh0OutEn;
    logic        asyncSerialClockCh1Out, asyncSerialClockCh1OutEn;
    logic        pinAddrTimer, pinClk0ReqIn, pinClk0ReqOut, pinClk0ReqOe;
    logic        pinClk1EndIn, pinClk1EndOut, pinClk1EndOe, pinRxCtsIn;
    logic        asyncSerialClockCh0In, dmaRequestCh0N;
    logic        asyncSerialClockCh1In, clockedSerialRx, clearToSendCh1N;
    int          n_mismatch, num_checks, n;

    mps_pin_select u_mps_pin_select (
        .clk_sys, .rst, .paddr, .psel, .penable, .pwrite, .pwdata,
        .pready, .prdata, .pslverr, .addressLine18,
        .asyncSerialClockCh0Out, .asyncSerialClockCh0OutEn,
        .asyncSerialClockCh1Out, .asyncSerialClockCh1OutEn,
        .dmaLastWrite, .pinAddrTimer, .pinClk0ReqIn, .pinClk0ReqOut,
        .pinClk0ReqOe, .pinClk1EndIn, .pinClk1EndOut, .pinClk1EndOe,
        .pinRxCtsIn, .asyncSerialClockCh0In, .dmaRequestCh0N,
        .asyncSerialClockCh1In, .clockedSerialRx, .clearToSendCh1N
    );
    mps_pin_partner u_mps_pin_partner (
        .extReq, .extClk1, .extRx,
        .clk0Out(pinClk0ReqOut), .clk0Oe(pinClk0ReqOe),
        .clk1Out(pinClk1EndOut), .clk1Oe(pinClk1EndOe),
        .clk0Pin(pinClk0ReqIn), .clk1Pin(pinClk1EndIn), .rxPin(pinRxCtsIn)
    );

    initial
    begin
        clk_sys = 1'h0;
        forever #4 clk_sys = ~clk_sys;
    end

    task automatic chkBit(input logic got, input logic exp, string msg);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t %s", $time, msg);
        end
    endtask

    task automatic chkWord(input logic [31:0] got, exp, string msg);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t %s", $time, msg);
        end
    endtask

    // Outputs are read right after an edge, before that edge's updates.
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_sys);
    endtask

    // The request stands until pready is seen high at a rising edge.
    task automatic apb(input logic wr, logic [11:0] a, logic [31:0] d);
        int w;
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'h1;
        w = 0;
        do
        begin
            @(posedge clk_sys);
            w++;
        end
        while (pready !== 1'h1 && w < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        if (w >= 20)
            n_mismatch++;
        // One edge passes so that a following call never reassigns psel
        // in the same time step.
        @(posedge clk_sys);
    endtask

    task automatic defaults();
        chkBit(pinAddrTimer, 1'h1, "address pin");
        chkBit(pinClk0ReqOut, 1'h1, "clock 0 out");
        chkBit(pinClk0ReqOe, 1'h1, "clock 0 drive");
        chkBit(asyncSerialClockCh0In, 1'h1, "clock 0 in");
        chkBit(dmaRequestCh0N, 1'h1, "dma request idle");
        chkBit(pinClk1EndOe, 1'h0, "clock 1 pin released");
        chkBit(asyncSerialClockCh1In, 1'h1, "clock 1 in");
        chkBit(clockedSerialRx, 1'h0, "receive data");
        chkBit(clearToSendCh1N, 1'h1, "cts idle");
    endtask

    task automatic results();
        $display("mismatches %0d checks %0d", n_mismatch, num_checks);
        if (n_mismatch == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial
    begin
        #80000;
        n_mismatch++;
        results();
    end

    initial
    begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        rst = 1'h1;
        {addressLine18, dmaLastWrite, asyncSerialClockCh1Out} = '0;
        {asyncSerialClockCh1OutEn} = 1'h0;
        {asyncSerialClockCh0Out, asyncSerialClockCh0OutEn} = 2'h3;
        {extReq, extClk1, extRx} = 3'h0;
        repeat (2) @(posedge clk_sys);
        rst <= 1'h0;
        addressLine18 <= 1'h1;
        extClk1 <= 1'h1;
        cyc(5);
        defaults();
        apb(1'h0, mps_pkg::PIN_CTRL_OFS, 32'h0000_0000);
        chkWord(rd, 32'h0000_0000, "control reset");
        apb(1'h0, mps_pkg::TIMER_RELOAD_OFS, 32'h0000_0000);
        chkWord(rd, 32'h0000_ffff, "reload reset");
        apb(1'h1, 12'h010, 32'h0000_0001);
        chkBit(err, 1'h1, "unmapped write refused");
        apb(1'h0, 12'h010, 32'h0000_0000);
        chkWord({rd[31:1], err}, 32'h0000_0001, "unmapped refused");
        for (int b = 0; b < 6; b++)
        begin
            ctl = 32'h0000_0001 << b;
            apb(1'h1, mps_pkg::PIN_CTRL_OFS, ctl);
            cyc(5);
            apb(1'h0, mps_pkg::PIN_STATUS_OFS, 32'h0000_0000);
            n = (b < 2) ? 0 : (b < 4) ? 1 : b - 2;
            chkWord(rd, 32'h0000_0001 << n, "status select");
            case (b)
                0, 1: chkBit(pinAddrTimer, 1'h0, "timer out");
                2, 3:
                begin
                    chkBit(pinClk0ReqOe, 1'h0, "clock 0 off");
                    chkBit(dmaRequestCh0N, 1'h0, "dma request");
                    chkBit(asyncSerialClockCh0In, 1'h0, "clk0 0");
                end
                4:
                begin
                    chkBit(pinClk1EndOut, 1'h1, "end idle");
                    chkBit(pinClk1EndOe, 1'h1, "end drive");
                    chkBit(asyncSerialClockCh1In, 1'h0, "clk1 0");
                    dmaLastWrite <= 1'h1;
                    cyc(1);
                    dmaLastWrite <= 1'h0;
                    cyc(1);
                    chkBit(pinClk1EndOut, 1'h0, "end low");
                    cyc(1);
                    chkBit(pinClk1EndOut, 1'h1, "end over");
                end
                default:
                begin
                    chkBit(clearToSendCh1N, 1'h0, "cts low");
                    chkBit(clockedSerialRx, 1'h1, "rx idle");
                end
            endcase
            apb(1'h1, mps_pkg::PIN_CTRL_OFS, 32'h0000_0000);
            cyc(5);
            defaults();
        end
        apb(1'h1, mps_pkg::TIMER_RELOAD_OFS, 32'h0000_0002);
        apb(1'h0, mps_pkg::TIMER_COUNT_OFS, 32'h0000_0000);
        chkWord(rd, 32'h0000_0002, "count loaded");
        apb(1'h1, mps_pkg::PIN_CTRL_OFS, 32'h0000_0042);
        // The first pass catches the switch from the address line and the
        // second the first period, itself a whole one; the third is checked.
        for (int k = 0; k < 3; k++)
        begin
            ctl[0] = pinAddrTimer;
            n = 0;
            while (pinAddrTimer === ctl[0] && n < 2000)
            begin
                cyc(1);
                n++;
            end
        end
        ctl = 32'(3 * mps_pkg::TIMER_PRESCALE_DIV);
        chkWord(32'(n), ctl, "period");
        results();
    end
endmodule // multiplexed_pin_select_tb
`default_nettype wire
